//--- core/ext_mem_pkg.sv
// Constants, types and decode functions of the external memory port.
`default_nettype none
package ext_mem_pkg;

    localparam logic [15:0] EXT_BASE_ADDR  = 16'h1100;
    localparam int          SECTOR_MSB     = 15;
    localparam int          SECTOR_LSB     = 13;
    localparam logic [2:0]  SECTOR_NONE    = 3'h0;
    localparam int          HIGH_BITS      = 8;
    localparam logic [3:0]  HIGH_FULL      = 4'h8;
    localparam logic [3:0]  HIGH_ZERO      = 4'h0;
    localparam logic [2:0]  HIGH_MASK_ALL  = 3'h7;
    localparam logic [2:0]  HIGH_MASK_NONE = 3'h0;
    localparam logic [1:0]  WAIT_NONE      = 2'h0;
    localparam logic [1:0]  WAIT_ONE       = 2'h1;
    localparam logic [1:0]  WAIT_TWO       = 2'h2;
    localparam logic [1:0]  WAIT_TWO_GAP   = 2'h3;
    localparam int          CTL_ALE        = 0;
    localparam int          CTL_RD         = 1;
    localparam int          CTL_WR         = 2;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ADDR   = 6'h02,
        ST_LATCH  = 6'h04,
        ST_STROBE = 6'h08,
        ST_GAP    = 6'h10,
        ST_TRAIL  = 6'h20
    } seq_state_t;

    // Extra strobe cycles for a wait code.
    function automatic logic [1:0] extra_waits(input logic [1:0] code);
        case (code)
            WAIT_NONE: extra_waits = 2'h0;
            WAIT_ONE:  extra_waits = 2'h1;
            default:   extra_waits = 2'h2;
        endcase
    endfunction

    // Number of high address lines owned by the port.
    function automatic logic [3:0] high_bits_used(input logic [2:0] mask);
        if (mask == HIGH_MASK_ALL) begin
            high_bits_used = HIGH_ZERO;
        end else begin
            high_bits_used = HIGH_FULL - {1'b0, mask};
        end
    endfunction

endpackage
`default_nettype wire

//--- core/external_memory_port.sv
// Access sequencer of the external memory port with its pin stage.
`default_nettype none
module external_memory_port
    import ext_mem_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    input  wire logic        next_is_ram,
    output logic             ack,
    output logic      [7:0]  rdata,
    output logic             busy,
    output logic             int_access,
    input  wire logic        ext_mem_enable,
    input  wire logic        legacy_mode,
    input  wire logic        upper_wait_msb,
    input  wire logic        upper_wait_lsb,
    input  wire logic        lower_wait_msb,
    input  wire logic        lower_wait_lsb,
    input  wire logic [2:0]  sector_limit_field,
    input  wire logic [2:0]  high_addr_mask_field,
    input  wire logic        bus_keeper_enable,
    input  wire logic [7:0]  port_ad_out,
    input  wire logic [7:0]  port_ad_dir,
    input  wire logic [7:0]  port_high_out,
    input  wire logic [7:0]  port_high_dir,
    input  wire logic [2:0]  port_ctl_out,
    input  wire logic [2:0]  port_ctl_dir,
    input  wire logic [7:0]  ad_in,
    output logic      [7:0]  muxed_addr_data_bus,
    output logic      [7:0]  muxed_addr_data_oe_n,
    output logic             ad_keeper_on,
    output logic      [7:0]  high_address_bus,
    output logic      [7:0]  high_address_oe_n,
    output logic             ale,
    output logic             ale_oe_n,
    output logic             rd_n,
    output logic             rd_oe_n,
    output logic             wr_n,
    output logic             wr_oe_n
);

    pin_drive_if pd ();

    seq_state_t  state_ff;
    logic [1:0]  cnt_ff;
    logic [1:0]  code_ff;
    logic [15:0] addr_ff;
    logic [7:0]  wdata_ff;
    logic        write_ff;
    logic        ext_ff;
    logic        busy_ff;
    logic        ack_ff;
    logic [7:0]  rdata_ff;
    logic        int_ff;
    logic [2:0]  cap_dly_ff;
    logic [7:0]  ad_meta_ff;
    logic [7:0]  ad_sync_ff;
    logic        accept;
    logic        is_ext;
    logic        upper_sel;
    logic [1:0]  nxt_code;
    logic        strobe_end;
    logic [7:0]  ad_pins;
    logic [7:0]  ad_oe_pins;
    logic [7:0]  high_pins;
    logic [7:0]  high_oe_pins;
    logic [2:0]  ctl_pins;
    logic [2:0]  ctl_oe_pins;
    logic        keeper_pin;

    // Two-stage synchroniser on the muxed bus input.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ad_meta_ff <= 8'h00;
            ad_sync_ff <= 8'h00;
        end else begin
            ad_meta_ff <= ad_in;
            ad_sync_ff <= ad_meta_ff;
        end
    end

    assign accept = req && !busy_ff;
    assign is_ext = req_addr >= EXT_BASE_ADDR;

    // Legacy mode has one sector and only the low wait bit.
    assign upper_sel = legacy_mode || (sector_limit_field == SECTOR_NONE) ||
                       (req_addr[SECTOR_MSB:SECTOR_LSB] >=
                        sector_limit_field);

    always_comb begin
        if (legacy_mode) begin
            nxt_code = {1'b0, upper_wait_lsb};
        end else if (upper_sel) begin
            nxt_code = {upper_wait_msb, upper_wait_lsb};
        end else begin
            nxt_code = {lower_wait_msb, lower_wait_lsb};
        end
    end

    assign strobe_end = (state_ff == ST_STROBE) && (cnt_ff == 2'h0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 2'h0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (accept && ext_mem_enable) begin
                        state_ff <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    state_ff <= ST_LATCH;
                end
                ST_LATCH: begin
                    state_ff <= ST_STROBE;
                    cnt_ff   <= extra_waits(code_ff);
                end
                ST_STROBE: begin
                    if (cnt_ff != 2'h0) begin
                        cnt_ff <= cnt_ff - 2'h1;
                    end else if (code_ff == WAIT_TWO_GAP) begin
                        state_ff <= ST_GAP;
                    end else begin
                        state_ff <= ST_TRAIL;
                    end
                end
                ST_GAP: begin
                    state_ff <= ST_TRAIL;
                end
                ST_TRAIL: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Request capture: address, data, direction, target and wait code.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ff  <= 16'h0000;
            wdata_ff <= 8'h00;
            write_ff <= 1'b0;
            ext_ff   <= 1'b0;
            code_ff  <= WAIT_NONE;
        end else if (accept) begin
            addr_ff  <= req_addr;
            wdata_ff <= req_wdata;
            write_ff <= req_write;
            ext_ff   <= is_ext;
            code_ff  <= nxt_code;
        end
    end

    // The pin level of the last strobe cycle leaves the synchroniser three
    // edges after the sequencer's last strobe state: pin stage plus two flops.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_dly_ff <= 3'h0;
        end else begin
            cap_dly_ff <= {cap_dly_ff[1:0], strobe_end};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff  <= 1'b0;
            ack_ff   <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff <= cap_dly_ff[2] || (accept && !ext_mem_enable);
            if (cap_dly_ff[2]) begin
                busy_ff  <= 1'b0;
                rdata_ff <= (ext_ff && !write_ff) ? ad_sync_ff
                                                  : 8'h00;
            end else if (accept && !ext_mem_enable) begin
                // Addresses above SRAM read zero when disabled.
                busy_ff  <= 1'b1;
                rdata_ff <= 8'h00;
            end else if (accept) begin
                busy_ff <= 1'b1;
            end else if (ack_ff) begin
                busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_ff <= 1'b0;
        end else if (accept) begin
            int_ff <= !is_ext;
        end else if (ack_ff) begin
            int_ff <= 1'b0;
        end
    end

    assign pd.enable    = ext_mem_enable;
    assign pd.legacy    = legacy_mode;
    assign pd.keeper    = bus_keeper_enable && !legacy_mode;
    assign pd.high_mask = legacy_mode ? HIGH_MASK_NONE
                                      : high_addr_mask_field;
    assign pd.ad_sync   = ad_sync_ff;
    assign pd.high_val  = addr_ff[15:8];
    // Address stays on the bus through the latch fall.
    assign pd.ad_val    = ((state_ff == ST_ADDR) || (state_ff == ST_LATCH))
                          ? addr_ff[7:0] : wdata_ff;
    assign pd.ad_drive  = (state_ff == ST_ADDR) || (state_ff == ST_LATCH) ||
                          (write_ff && ((state_ff == ST_STROBE) ||
                                        (state_ff == ST_GAP)));
    assign pd.ale_v     = (state_ff == ST_ADDR) ||
                          ((state_ff == ST_TRAIL) && next_is_ram);
    // Strobes stay high for internal accesses.
    assign pd.rd_v_n    = !((state_ff == ST_STROBE) && ext_ff &&
                            !write_ff);
    assign pd.wr_v_n    = !((state_ff == ST_STROBE) && ext_ff &&
                            write_ff);

    pin_stage u_pins (
        .clk           (clk),
        .rst           (rst),
        .pd            (pd),
        .port_ad_out   (port_ad_out),
        .port_ad_dir   (port_ad_dir),
        .port_high_out (port_high_out),
        .port_high_dir (port_high_dir),
        .port_ctl_out  (port_ctl_out),
        .port_ctl_dir  (port_ctl_dir),
        .ad_out_ff     (ad_pins),
        .ad_oe_n_ff    (ad_oe_pins),
        .keeper_on_ff  (keeper_pin),
        .high_out_ff   (high_pins),
        .high_oe_n_ff  (high_oe_pins),
        .ctl_out_ff    (ctl_pins),
        .ctl_oe_n_ff   (ctl_oe_pins)
    );

    assign ack                  = ack_ff;
    assign rdata                = rdata_ff;
    assign busy                 = busy_ff;
    assign int_access           = int_ff;
    assign muxed_addr_data_bus  = ad_pins;
    assign muxed_addr_data_oe_n = ad_oe_pins;
    assign ad_keeper_on         = keeper_pin;
    assign high_address_bus     = high_pins;
    assign high_address_oe_n    = high_oe_pins;
    assign ale                  = ctl_pins[CTL_ALE];
    assign ale_oe_n             = ctl_oe_pins[CTL_ALE];
    assign rd_n                 = ctl_pins[CTL_RD];
    assign rd_oe_n              = ctl_oe_pins[CTL_RD];
    assign wr_n                 = ctl_pins[CTL_WR];
    assign wr_oe_n              = ctl_oe_pins[CTL_WR];

endmodule
`default_nettype wire

//--- core/pin_drive_if.sv
// Pin drive request passed from the access sequencer to the pin stage.
`default_nettype none
interface pin_drive_if;
    logic       enable;
    logic       legacy;
    logic       keeper;
    logic [2:0] high_mask;
    logic [7:0] ad_val;
    logic       ad_drive;
    logic [7:0] ad_sync;
    logic [7:0] high_val;
    logic       ale_v;
    logic       rd_v_n;
    logic       wr_v_n;

    modport seq (output enable, legacy, keeper, high_mask, ad_val, ad_drive,
                 ad_sync, high_val, ale_v, rd_v_n, wr_v_n);
    modport mux (input enable, legacy, keeper, high_mask, ad_val, ad_drive,
                 ad_sync, high_val, ale_v, rd_v_n, wr_v_n);
endinterface
`default_nettype wire

//--- core/pin_stage.sv
// Registered pin stage: port override, high address release and bus keeper.
`default_nettype none
module pin_stage
    import ext_mem_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    pin_drive_if.mux        pd,
    input  wire logic [7:0] port_ad_out,
    input  wire logic [7:0] port_ad_dir,
    input  wire logic [7:0] port_high_out,
    input  wire logic [7:0] port_high_dir,
    input  wire logic [2:0] port_ctl_out,
    input  wire logic [2:0] port_ctl_dir,
    output logic      [7:0] ad_out_ff,
    output logic      [7:0] ad_oe_n_ff,
    output logic            keeper_on_ff,
    output logic      [7:0] high_out_ff,
    output logic      [7:0] high_oe_n_ff,
    output logic      [2:0] ctl_out_ff,
    output logic      [2:0] ctl_oe_n_ff
);

    logic [3:0] used_bits;

    assign used_bits = high_bits_used(pd.high_mask);

    genvar i;
    generate
        for (i = 0; i < HIGH_BITS; i++) begin : g_bit
            logic ad_drv;
            logic ad_v;
            logic hi_mem;

            // Memory function wins over the direction bits when enabled.
            assign ad_drv = pd.enable ? pd.ad_drive : port_ad_dir[i];
            // A released line shows its last seen level for the keeper.
            assign ad_v   = !ad_drv ? pd.ad_sync[i] :
                            (pd.enable ? pd.ad_val[i] : port_ad_out[i]);
            assign hi_mem = pd.enable && (i < used_bits);

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ad_out_ff[i]    <= 1'b0;
                    ad_oe_n_ff[i]   <= 1'b1;
                    high_out_ff[i]  <= 1'b0;
                    high_oe_n_ff[i] <= 1'b1;
                end else begin
                    ad_out_ff[i]    <= ad_v;
                    ad_oe_n_ff[i]   <= ~ad_drv;
                    high_out_ff[i]  <= hi_mem ? pd.high_val[i]
                                              : port_high_out[i];
                    high_oe_n_ff[i] <= hi_mem ? 1'b0 : ~port_high_dir[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            keeper_on_ff <= 1'b0;
        end else begin
            // Keeper is not gated by the enable bit.
            keeper_on_ff <= pd.keeper;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_out_ff  <= 3'h6;
            ctl_oe_n_ff <= 3'h7;
        end else if (pd.enable) begin
            ctl_out_ff  <= {pd.wr_v_n, pd.rd_v_n, pd.ale_v};
            ctl_oe_n_ff <= 3'h0;
        end else begin
            ctl_out_ff  <= port_ctl_out;
            ctl_oe_n_ff <= pd.legacy ? 3'h0 : ~port_ctl_dir;
        end
    end

endmodule
`default_nettype wire

//--- tb/ext_mem_port_assertions.sv
// Assertion checker for the external memory port top-level pins.
`default_nettype none
module ext_mem_port_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req,
    input wire logic        busy,
    input wire logic        ack,
    input wire logic        int_access,
    input wire logic        next_is_ram,
    input wire logic        ext_mem_enable,
    input wire logic        legacy_mode,
    input wire logic        upper_wait_msb,
    input wire logic        upper_wait_lsb,
    input wire logic        lower_wait_msb,
    input wire logic        lower_wait_lsb,
    input wire logic        bus_keeper_enable,
    input wire logic        ad_keeper_on,
    input wire logic        ale,
    input wire logic        ale_oe_n,
    input wire logic        rd_n,
    input wire logic        rd_oe_n,
    input wire logic        wr_n,
    input wire logic        wr_oe_n,
    input wire logic [15:0] req_addr,
    input wire logic [2:0]  sector_limit_field,
    input wire logic [2:0]  port_ctl_out,
    input wire logic [2:0]  port_ctl_dir,
    input wire logic [7:0]  muxed_addr_data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] code;
    logic [1:0] code_ff;
    logic       en_ff;
    logic [3:0] cnt_ff;
    logic [3:0] low_ff;
    logic [3:0] w;
    logic       strb;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    assign strb = !rd_n || !wr_n;
    assign code = legacy_mode ? {1'b0, upper_wait_lsb} :
        (sector_limit_field == 3'h0 || req_addr[15:13] >= sector_limit_field)
        ? {upper_wait_msb, upper_wait_lsb} : {lower_wait_msb, lower_wait_lsb};
    assign w = (code_ff == 2'h0) ? 4'h0 : (code_ff == 2'h1) ? 4'h1 : 4'h2;
    // Cycles since the last accepted request and the wait code it used.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= 4'h0;
            en_ff   <= 1'b0;
            code_ff <= 2'h0;
        end else if (req && !busy) begin
            cnt_ff  <= 4'h1;
            en_ff   <= ext_mem_enable;
            code_ff <= code;
        end else if (cnt_ff != 4'hF) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_ff <= 4'h0;
        end else begin
            low_ff <= strb ? low_ff + 4'h1 : 4'h0;
        end
    end
    property p_ack_time;
        ack && en_ff |-> cnt_ff == 4'h7 + w;
    endproperty
    a_ack_time: assert property (p_ack_time)
        else $error("ack arrived at the wrong cycle");
    property p_strobe_len;
        ext_mem_enable && !strb && low_ff != 4'h0 |-> low_ff == 4'h1 + w;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe length does not match the wait code");
    property p_ale_low;
        ext_mem_enable && strb |-> !ale;
    endproperty
    a_ale_low: assert property (p_ale_low)
        else $error("latch strobe high during data transfer");
    property p_wr_drive;
        ext_mem_enable && !wr_n |-> muxed_addr_data_oe_n == 8'h00;
    endproperty
    a_wr_drive: assert property (p_wr_drive)
        else $error("bus not driven during write strobe");
    property p_rd_release;
        ext_mem_enable && !rd_n |-> muxed_addr_data_oe_n == 8'hFF;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("bus not released during read strobe");
    property p_internal;
        int_access |-> rd_n && wr_n;
    endproperty
    a_internal: assert property (p_internal)
        else $error("strobe active on an internal access");
    property p_trail;
        en_ff && code_ff != 2'h3 && !strb && low_ff != 4'h0 |->
            ale == $past(next_is_ram);
    endproperty
    a_trail: assert property (p_trail)
        else $error("trailing latch pulse wrong");
    property p_legacy_out;
        legacy_mode && $past(legacy_mode) && !$past(rst) |->
            !ale_oe_n && !rd_oe_n && !wr_oe_n;
    endproperty
    a_legacy_out: assert property (p_legacy_out)
        else $error("control pin not an output in legacy mode");
    property p_port_follow;
        !ext_mem_enable && !$past(ext_mem_enable) && !legacy_mode &&
        !$past(legacy_mode) && !$past(rst) |->
        rd_oe_n == !$past(port_ctl_dir[1]) && rd_n == $past(port_ctl_out[1]);
    endproperty
    a_port_follow: assert property (p_port_follow)
        else $error("disabled pin does not follow port settings");
    property p_enable_own;
        ext_mem_enable && $past(ext_mem_enable) && !$past(rst) |->
            !ale_oe_n && !rd_oe_n && !wr_oe_n;
    endproperty
    a_enable_own: assert property (p_enable_own)
        else $error("control pins not owned while enabled");
    property p_keeper;
        !$past(rst) |->
        ad_keeper_on == ($past(bus_keeper_enable) && !$past(legacy_mode));
    endproperty
    a_keeper: assert property (p_keeper)
        else $error("bus keeper state wrong");
    c_ext_ack: cover property (ack && en_ff && !int_access);
    c_int: cover property (int_access && ack);
    c_legacy: cover property (legacy_mode && ack);
    c_write: cover property (!wr_n && ext_mem_enable);
endmodule
bind external_memory_port ext_mem_port_checker ext_mem_port_checker_i (
    .clk, .rst, .req, .busy, .ack, .int_access, .next_is_ram,
    .ext_mem_enable, .legacy_mode, .upper_wait_msb, .upper_wait_lsb,
    .lower_wait_msb, .lower_wait_lsb, .bus_keeper_enable, .ad_keeper_on,
    .ale, .ale_oe_n, .rd_n, .rd_oe_n, .wr_n, .wr_oe_n, .req_addr,
    .sector_limit_field, .port_ctl_out, .port_ctl_dir, .muxed_addr_data_oe_n
);
`default_nettype wire

//--- tb/sram_model.sv
// Far-side model: address latch plus a byte-wide static memory.
`default_nettype none
module sram_model (
    input  wire logic       clk,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] bus,
    input  wire logic [7:0] bus_oe_n,
    input  wire logic [7:0] high,
    input  wire logic       keeper_on,
    output logic      [7:0] ad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] low_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [7:0] rd_val;
    // The latch closes on the strobe edge itself, not on a clock phase.
    always @(negedge ale) low_q = bus;
    always @(posedge clk) if (!wr_n) mem[{high, low_q}] <= bus;
    always @(posedge clk) last_q <= ad_in;
    assign rd_val = mem[{high, low_q}];
    // A floating line toggles each cycle unless the keeper holds it.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ad_in[i] = !bus_oe_n[i] ? bus[i] : !rd_n ? rd_val[i] :
                keeper_on ? last_q[i] : !last_q[i];
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the external memory port.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, req, req_write, next_is_ram, ack, busy;
    logic        int_access, ext_mem_enable, legacy_mode, ad_keeper_on;
    logic        upper_wait_msb, upper_wait_lsb, lower_wait_msb;
    logic        lower_wait_lsb, bus_keeper_enable, ale, ale_oe_n;
    logic        rd_n, rd_oe_n, wr_n, wr_oe_n;
    logic [15:0] req_addr;
    logic [7:0]  req_wdata, rdata, port_ad_out, port_ad_dir, port_high_out;
    logic [7:0]  port_high_dir, ad_in, muxed_addr_data_bus;
    logic [7:0]  muxed_addr_data_oe_n, high_address_bus, high_address_oe_n;
    logic [2:0]  sector_limit_field, high_addr_mask_field, port_ctl_out;
    logic [2:0]  port_ctl_dir;
    int          n_mismatch, checks_done, n;
    logic        s, i;
    external_memory_port external_memory_port_i (
        .clk, .rst, .req, .req_write, .req_addr, .req_wdata, .next_is_ram,
        .ack, .rdata, .busy, .int_access, .ext_mem_enable, .legacy_mode,
        .upper_wait_msb, .upper_wait_lsb, .lower_wait_msb, .lower_wait_lsb,
        .sector_limit_field, .high_addr_mask_field, .bus_keeper_enable,
        .port_ad_out, .port_ad_dir, .port_high_out, .port_high_dir,
        .port_ctl_out, .port_ctl_dir, .ad_in, .muxed_addr_data_bus,
        .muxed_addr_data_oe_n, .ad_keeper_on, .high_address_bus,
        .high_address_oe_n, .ale, .ale_oe_n, .rd_n, .rd_oe_n, .wr_n, .wr_oe_n
    );
    sram_model sram_model_i (
        .clk, .ale, .rd_n, .wr_n, .bus(muxed_addr_data_bus),
        .bus_oe_n(muxed_addr_data_oe_n), .high(high_address_bus),
        .keeper_on(ad_keeper_on), .ad_in
    );
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Runs one access and counts falling edges from acceptance to ack.
    task automatic access(logic wr, logic [15:0] a, logic [7:0] d);
        n = 0;
        s = 0;
        i = 0;
        @(negedge clk);
        req = 1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req = 0;
        while (ack !== 1'b1 && n < 20) begin
            s |= !rd_n || !wr_n;
            i |= int_access;
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_waits;
        for (int c = 0; c < 4; c++) begin
            {upper_wait_msb, upper_wait_lsb} = 2'(c);
            next_is_ram = c[0];
            access(1, 16'h2000 + 16'(c), 8'hA0 + 8'(c));
            chk("cycles", 16'(c > 1 ? 8 : 6 + c), 16'(n));
            access(0, 16'h2000 + 16'(c), 8'h00);
            chk("read data", 16'hA0 + 16'(c), {8'h00, rdata});
            chk("strobe", 16'h0001, {15'h0, s});
        end
        $display("test wait codes done");
    endtask
    task automatic t_sectors;
        sector_limit_field = 3'h3;
        {upper_wait_msb, upper_wait_lsb} = 2'h2;
        access(1, 16'h5FFF, 8'h5A);
        chk("lower cycles", 16'h0006, 16'(n));
        access(1, 16'h6000, 8'hC3);
        chk("upper cycles", 16'h0008, 16'(n));
        access(0, 16'h5FFF, 8'h00);
        chk("lower data", 16'h005A, {8'h00, rdata});
        $display("test sectors done");
    endtask
    task automatic t_internal;
        {upper_wait_msb, upper_wait_lsb} = 2'h0;
        access(1, 16'h10FF, 8'h33);
        chk("int strobe", 16'h0000, {15'h0, s});
        chk("int flag", 16'h0001, {15'h0, i});
        chk("int cycles", 16'h0006, 16'(n));
        access(1, 16'h1100, 8'h44);
        chk("ext flag", 16'h0000, {15'h0, i});
        $display("test internal done");
    endtask
    task automatic t_disabled;
        ext_mem_enable = 0;
        port_ctl_dir = 3'h5;
        port_high_out = 8'h3C;
        port_high_dir = 8'hF0;
        access(0, 16'h3000, 8'h00);
        chk("off rdata", 16'h0000, {8'h00, rdata});
        chk("off strobe", 16'h0000, {15'h0, s});
        chk("off high", 16'h3C0F, {high_address_bus, high_address_oe_n});
        port_ctl_out = 3'h5;
        repeat (2) @(negedge clk);
        chk("off rd", 16'h0001, {14'h0, rd_n, rd_oe_n});
        port_ctl_out = 3'h7;
        repeat (2) @(negedge clk);
        ext_mem_enable = 1;
        port_high_dir = 8'h00;
        $display("test disabled done");
    endtask
    task automatic t_mask;
        high_addr_mask_field = 3'h3;
        repeat (2) @(negedge clk);
        chk("mask 3", 16'h00E0, {8'h00, high_address_oe_n});
        high_addr_mask_field = 3'h7;
        repeat (2) @(negedge clk);
        chk("mask 7", 16'h00FF, {8'h00, high_address_oe_n});
        high_addr_mask_field = 3'h3;
        $display("test mask done");
    endtask
    task automatic t_legacy;
        legacy_mode = 1;
        bus_keeper_enable = 1;
        {upper_wait_msb, upper_wait_lsb} = 2'h3;
        {lower_wait_msb, lower_wait_lsb} = 2'h3;
        access(1, 16'h5000, 8'h77);
        chk("legacy cycles", 16'h0007, 16'(n));
        chk("legacy keeper", 16'h0000, {15'h0, ad_keeper_on});
        chk("legacy high", 16'h0000, {8'h00, high_address_oe_n});
        chk("legacy ctl", 16'h0000, {13'h0, ale_oe_n, rd_oe_n, wr_oe_n});
        upper_wait_lsb = 0;
        access(0, 16'h5000, 8'h00);
        chk("legacy none", 16'h0006, 16'(n));
        chk("legacy data", 16'h0077, {8'h00, rdata});
        legacy_mode = 0;
        repeat (2) @(negedge clk);
        chk("keeper", 16'h0001, {15'h0, ad_keeper_on});
        $display("test legacy done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        {rst, req, req_write, next_is_ram, legacy_mode} = 5'h10;
        {upper_wait_msb, upper_wait_lsb, lower_wait_msb} = 3'h0;
        {lower_wait_lsb, bus_keeper_enable, ext_mem_enable} = 3'h1;
        {req_addr, req_wdata, port_ad_dir, port_high_out} = 40'h0;
        port_ad_out = 8'h00;
        {port_high_dir, sector_limit_field, high_addr_mask_field} = 14'h0;
        {port_ctl_out, port_ctl_dir} = 6'h38;
        {n_mismatch, checks_done} = 0;
        repeat (12) @(negedge clk);
        rst = 0;
        t_waits();
        t_sectors();
        t_internal();
        t_disabled();
        t_mask();
        t_legacy();
        close_out();
    end
endmodule
`default_nettype wire
